// [logic/mpsf_consts.svh]
// Register numbers, reset values and timing of the status flag bank.
// Assumes a 50 MHz core clock.
//
// Contract
// (R01) in_reset_flag is 1 during reset, 0 once reset completes.
// (R02) Carrier flag sets on entering a data mode, ready to transmit.
// (R03) V.29 receive: carrier flag sets on data mode entry, ready to receive.
// (R04) Carrier flag clears during retrain and with no remote signal.
// (R05) line_signal_out is the inverse of the carrier flag.
// (R06) Carrier flag clears on any reset and on standby.
// (R07) retrain_seen_flag sets on remote retrain request, V.22bis 2400 only.
// (R08) pump_busy_flag sets when transmit starts with send request high.
// (R09) With send request low, busy clears once transmit buffers drain.
// (R10) Host waits for busy low before standby and on-hook.
// (R11) Busy is also high while timed dialing sends digits.
// (R12) Busy clears on any reset and on standby.
// (R13) Host ignores busy while HDLC framing is in use.
// (R14) After reset, rx_byte_flag reads 1, other status bits 0.
// (R15) Status bit 3 is reserved, reads 0.
// (R16) ram_done_flag sets when a host RAM access is processed.
// (R17) Parallel mode: rx_byte_flag sets on each new received octet.
// (R18) A host read of parallel_data_reg clears rx_byte_flag.
// (R19) Parallel mode: tx_byte_flag sets when the pump takes the host byte.
// (R20) A host write of parallel_data_reg clears tx_byte_flag.
// (R21) HDLC: bit2 frame closed, bit1 frame error, bit0 end; rest 0.
// (R22) host_irq_pin ORs the three flag-and-enable terms.
// (R23) parallel_mode_select 1 picks parallel transfer, 0 serial.
// (R24) Host writes to the status register have no effect.
`ifndef MPSF_CONSTS_SVH
`define MPSF_CONSTS_SVH

// Register numbers on the host port
`define MPSF_REG_RAM_LOW    3'h0
`define MPSF_REG_RAM_HIGH   3'h1
`define MPSF_REG_RAM_ADDR   3'h2
`define MPSF_REG_PAR_DATA   3'h3
`define MPSF_REG_RAM_CTRL   3'h4
`define MPSF_REG_STATUS     3'h5
`define MPSF_REG_HDLC       3'h7

// Reset values
`define MPSF_BYTE_ZERO      8'h00
`define MPSF_FW_VERSION     8'h5a
`define MPSF_MODE_STANDBY   7'h00

// Reset sequence length
`define MPSF_CLK_PERIOD_NS  20
`define MPSF_RESET_SEQ_NS   1000
`define MPSF_RESET_SEQ_CYC  (`MPSF_RESET_SEQ_NS / `MPSF_CLK_PERIOD_NS)
`define MPSF_SEQ_ONE        8'h01

`endif

// [logic/mpsf_pkg.sv]
// Types of the modem pump status flag bank.
// Assumes mpsf_consts.svh provides the numeric constants.
`default_nettype none
package mpsf_pkg;

   // Status register layout, bit 7 first
   typedef struct packed {
      logic tx_byte_flag;
      logic rx_byte_flag;
      logic ram_done_flag;
      logic pump_busy_flag;
      logic reserved3;
      logic retrain_seen_flag;
      logic carrier_present_flag;
      logic in_reset_flag;
   } mpsf_status_t;

   // RAM control register layout, bit 7 first
   typedef struct packed {
      logic tx_irq_enable;
      logic rx_irq_enable;
      logic ram_irq_enable;
      logic parallel_mode_select;
      logic soft_send_request;
      logic ram_write;
      logic ram_request;
      logic ram_addr_high;
   } mpsf_ctrl_t;

   // HDLC frame status, low three bits used
   typedef struct packed {
      logic [4:0] zero;
      logic       tx_frame_closed;
      logic       rx_frame_error;
      logic       rx_frame_end;
   } mpsf_hdlc_t;

   // Events and levels from the pump engines, same clock domain
   typedef struct packed {
      logic       data_mode_ready;
      logic       v29_rx_ready;
      logic       retrain_active;
      logic       no_remote_signal;
      logic       v22bis_2400_mode;
      logic       retrain_request;
      logic       tx_start;
      logic       tx_buffers_empty;
      logic       dialing_active;
      logic       ram_done;
      logic       rx_octet_valid;
      logic [7:0] rx_octet;
      logic       tx_octet_taken;
      logic       standby_write;
      logic [2:0] hdlc_bits;
   } mpsf_pump_ev_t;

   // Host port pins as one vector for the synchroniser
   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       rts_n;
      logic [2:0] addr;
      logic [7:0] data;
   } mpsf_host_pins_t;

   typedef enum logic [0:0] {PH_RESET, PH_RUN} mpsf_phase_t;

endpackage
`default_nettype wire

// [logic/mpsf_status.sv]
// Modem pump host register port and status flag bank.
// Assumes the host pins are asynchronous to core_clk; pump events
// arrive on core_clk from the pump engines.
`timescale 1ns/1ps
`default_nettype none
`include "mpsf_consts.svh"
module mpsf_status
   import mpsf_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          reset_n,
   input  wire logic          host_cs_n,
   input  wire logic          host_rd_n,
   input  wire logic          host_wr_n,
   input  wire logic [2:0]    host_addr,
   input  wire logic [7:0]    host_data_in,
   output var  logic [7:0]    host_data_out,
   output var  logic          host_data_oe,
   output var  logic          host_irq_pin,
   input  wire logic          rts_pin_n,
   output var  logic          line_signal_out_n,
   input  wire mpsf_pump_ev_t pump_ev,
   input  wire logic [15:0]   ram_read_data,
   output var  logic          ram_request,
   output var  logic          ram_write,
   output var  logic [8:0]    ram_address,
   output var  logic [15:0]   ram_write_data,
   output var  logic [7:0]    tx_octet,
   output var  logic          parallel_mode,
   output var  logic          send_request
);

   // Reset sequence counter width
   localparam int SEQ_W = 8;

   mpsf_host_pins_t pins_raw;
   mpsf_host_pins_t pins;
   mpsf_phase_t     phase;
   logic [SEQ_W-1:0] seq_count;
   logic            seq_done;
   mpsf_status_t    status;
   mpsf_ctrl_t      ctrl;
   mpsf_hdlc_t      hdlc;
   logic [7:0]      ram_low;
   logic [7:0]      ram_high;
   logic [7:0]      ram_addr_low;
   logic [7:0]      par_data;
   logic            rd_active;
   logic            wr_active;
   logic            rd_prev;
   logic            wr_prev;
   logic            rd_start;
   logic            rd_end;
   logic            wr_end;
   logic [2:0]      rd_addr_held;
   logic [2:0]      wr_addr_held;
   logic [7:0]      wr_data_held;
   logic            host_wr_data;
   logic            host_rd_data;
   logic            standby;
   logic            running;
   logic            send_req_any;
   logic [7:0]      next_read_byte;

   // Readback of one register; numbers 2 and 6 read zero
   function automatic logic [7:0] reg_read(input logic [2:0] a,
                                           input mpsf_status_t s,
                                           input mpsf_ctrl_t c,
                                           input mpsf_hdlc_t h,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input logic [7:0] pd);
      logic [7:0] r;
      r = `MPSF_BYTE_ZERO;
      if (a == `MPSF_REG_RAM_LOW) begin
         r = lo;
      end else if (a == `MPSF_REG_RAM_HIGH) begin
         r = hi;
      end else if (a == `MPSF_REG_PAR_DATA) begin
         r = pd;
      end else if (a == `MPSF_REG_RAM_CTRL) begin
         r = c;
      end else if (a == `MPSF_REG_STATUS) begin
         r = s;
      end else if (a == `MPSF_REG_HDLC) begin
         r = h;
      end
      return r;
   endfunction

   // Pins pass two flops before anything looks at them
   assign pins_raw.cs_n  = host_cs_n;
   assign pins_raw.rd_n  = host_rd_n;
   assign pins_raw.wr_n  = host_wr_n;
   assign pins_raw.rts_n = rts_pin_n;
   assign pins_raw.addr  = host_addr;
   assign pins_raw.data  = host_data_in;

   mpsf_sync #(
      .W ($bits(mpsf_host_pins_t))
   ) u_pin_sync (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .async_in    (pins_raw),
      .sync_out    (pins)
   );

   // Strobe decode on the synchronised pins
   assign rd_active = !pins.cs_n && !pins.rd_n;
   assign wr_active = !pins.cs_n && !pins.wr_n;
   assign rd_start  = rd_active && !rd_prev;
   assign rd_end    = !rd_active && rd_prev;
   assign wr_end    = !wr_active && wr_prev;

   // Side effects happen once, at the end of a strobe
   assign host_rd_data = rd_end && (rd_addr_held == `MPSF_REG_PAR_DATA);
   assign host_wr_data = wr_end && (wr_addr_held == `MPSF_REG_PAR_DATA);

   assign standby      = pump_ev.standby_write;
   assign running      = (phase == PH_RUN);
   assign send_req_any = ctrl.soft_send_request || !pins.rts_n;

   // Strobe history and held address and data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_prev      <= 1'b0;
         wr_prev      <= 1'b0;
         rd_addr_held <= 3'h0;
         wr_addr_held <= 3'h0;
         wr_data_held <= `MPSF_BYTE_ZERO;
      end else begin
         rd_prev <= rd_active;
         wr_prev <= wr_active;
         if (rd_start) begin
            rd_addr_held <= pins.addr;
         end
         // Data sampled while the strobe is still low, before it rises
         if (wr_active) begin
            wr_addr_held <= pins.addr;
            wr_data_held <= pins.data;
         end
      end
   end

   // Reset sequence: flag high until the counter runs out
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase     <= PH_RESET;
         seq_count <= SEQ_W'(`MPSF_RESET_SEQ_CYC);
      end else begin
         case (phase)
            PH_RESET: begin
               if (seq_count == `MPSF_SEQ_ONE) begin
                  phase <= PH_RUN;
               end
               seq_count <= seq_count - `MPSF_SEQ_ONE;
            end
            PH_RUN: begin
               seq_count <= seq_count;
            end
            default: begin
               phase <= PH_RESET;
            end
         endcase
      end
   end

   assign seq_done = (phase == PH_RESET) && (seq_count == `MPSF_SEQ_ONE);

   // Reset-in-progress flag
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.in_reset_flag <= 1'b1;
      end else if (seq_done) begin
         status.in_reset_flag <= 1'b0;                       // [R01]
      end
   end

   // Carrier detect; clearing conditions outrank entry events because
   // they are levels that must hold the flag low for their whole span
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.carrier_present_flag <= 1'b0;                // [R06]
      end else if (!running || standby) begin
         status.carrier_present_flag <= 1'b0;                // [R06] [R14]
      end else if (pump_ev.retrain_active || pump_ev.no_remote_signal) begin
         status.carrier_present_flag <= 1'b0;                // [R04]
      end else if (pump_ev.data_mode_ready) begin
         status.carrier_present_flag <= 1'b1;                // [R02]
      end else if (pump_ev.v29_rx_ready) begin
         status.carrier_present_flag <= 1'b1;                // [R03]
      end
   end

   // Retrain seen, only in the 2400 bps mode; dropped on standby
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.retrain_seen_flag <= 1'b0;
      end else if (!running || standby) begin
         status.retrain_seen_flag <= 1'b0;                   // [R14]
      end else if (pump_ev.retrain_request && pump_ev.v22bis_2400_mode) begin
         status.retrain_seen_flag <= 1'b1;                   // [R07]
      end else if (!pump_ev.v22bis_2400_mode) begin
         status.retrain_seen_flag <= 1'b0;
      end
   end

   // Busy: set on transmit start, cleared once buffers drain
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.pump_busy_flag <= 1'b0;                      // [R12]
      end else if (!running || standby) begin
         status.pump_busy_flag <= 1'b0;                      // [R12] [R14]
      end else if (pump_ev.tx_start && send_req_any) begin
         status.pump_busy_flag <= 1'b1;                      // [R08]
      end else if (pump_ev.dialing_active) begin
         status.pump_busy_flag <= 1'b1;                      // [R11]
      end else if (!send_req_any && pump_ev.tx_buffers_empty) begin
         status.pump_busy_flag <= 1'b0;                      // [R09]
      end
   end

   // Reserved bit never changes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.reserved3 <= 1'b0;
      end else begin
         status.reserved3 <= 1'b0;                           // [R15]
      end
   end

   // RAM done; a new control write with a request clears it, done wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.ram_done_flag <= 1'b0;
      end else if (!running) begin
         status.ram_done_flag <= 1'b0;                       // [R14]
      end else if (pump_ev.ram_done && ctrl.ram_request) begin
         status.ram_done_flag <= 1'b1;                       // [R16]
      end else if (wr_end && wr_addr_held == `MPSF_REG_RAM_CTRL &&
                   wr_data_held[1]) begin
         status.ram_done_flag <= 1'b0;
      end
   end

   // Receive byte flag: set wins over the read that clears it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.rx_byte_flag <= 1'b0;
      end else if (seq_done) begin
         status.rx_byte_flag <= 1'b1;                        // [R14]
      end else if (running && ctrl.parallel_mode_select &&
                   pump_ev.rx_octet_valid) begin
         status.rx_byte_flag <= 1'b1;                        // [R17]
      end else if (host_rd_data) begin
         status.rx_byte_flag <= 1'b0;                        // [R18]
      end
   end

   // Transmit byte flag: set wins over the write that clears it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status.tx_byte_flag <= 1'b0;
      end else if (!running) begin
         status.tx_byte_flag <= 1'b0;                        // [R14]
      end else if (ctrl.parallel_mode_select && pump_ev.tx_octet_taken) begin
         status.tx_byte_flag <= 1'b1;                        // [R19]
      end else if (host_wr_data) begin
         status.tx_byte_flag <= 1'b0;                        // [R20]
      end
   end

   // HDLC frame status follows the framer, zero in reset and standby
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hdlc <= '0;
      end else if (!running || standby) begin
         hdlc <= '0;
      end else begin
         hdlc.zero            <= '0;                         // [R21]
         hdlc.tx_frame_closed <= pump_ev.hdlc_bits[2];       // [R21]
         hdlc.rx_frame_error  <= pump_ev.hdlc_bits[1];
         hdlc.rx_frame_end    <= pump_ev.hdlc_bits[0];
      end
   end

   // Parallel data: host writes, received octets and version byte
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         par_data <= `MPSF_FW_VERSION;
      end else if (!running || standby) begin
         par_data <= `MPSF_FW_VERSION;
      end else if (host_wr_data) begin
         par_data <= wr_data_held;
      end else if (ctrl.parallel_mode_select && pump_ev.rx_octet_valid) begin
         par_data <= pump_ev.rx_octet;                       // [R23]
      end
   end

   // RAM control; the request bit is dropped by the pump when served
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= '0;
      end else if (!running) begin
         ctrl <= '0;
      end else if (wr_end && wr_addr_held == `MPSF_REG_RAM_CTRL) begin
         ctrl <= wr_data_held;                               // [R23]
      end else if (pump_ev.ram_done) begin
         ctrl.ram_request <= 1'b0;
      end
   end

   // RAM data and address registers; a served read loads the data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ram_low      <= `MPSF_BYTE_ZERO;
         ram_high     <= `MPSF_BYTE_ZERO;
         ram_addr_low <= `MPSF_BYTE_ZERO;
      end else if (wr_end && wr_addr_held == `MPSF_REG_RAM_LOW) begin
         ram_low <= wr_data_held;
      end else if (wr_end && wr_addr_held == `MPSF_REG_RAM_HIGH) begin
         ram_high <= wr_data_held;
      end else if (wr_end && wr_addr_held == `MPSF_REG_RAM_ADDR) begin
         ram_addr_low <= wr_data_held;
      end else if (pump_ev.ram_done && ctrl.ram_request &&
                   !ctrl.ram_write) begin
         ram_low  <= ram_read_data[7:0];
         ram_high <= ram_read_data[15:8];
      end
   end

   // Read data captured at the start of the read strobe; writes to the
   // status and HDLC numbers fall through the decode untouched
   assign next_read_byte = reg_read(pins.addr, status, ctrl, hdlc,
                                    ram_low, ram_high, par_data); // [R24]

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_data_out <= `MPSF_BYTE_ZERO;
      end else if (rd_start) begin
         host_data_out <= next_read_byte;
      end
   end

   // Bus drive only while a read strobe is seen
   assign host_data_oe = rd_active && rd_prev;

   // Interrupt pin and line signal
   assign host_irq_pin = (status.ram_done_flag && ctrl.ram_irq_enable) ||
                         (status.rx_byte_flag && ctrl.rx_irq_enable) ||
                         (status.tx_byte_flag && ctrl.tx_irq_enable); // [R22]
   assign line_signal_out_n = !status.carrier_present_flag;          // [R05]

   // Outputs to the pump engines
   assign ram_request    = ctrl.ram_request;
   assign ram_write      = ctrl.ram_write;
   assign ram_address    = {ctrl.ram_addr_high, ram_addr_low};
   assign ram_write_data = {ram_high, ram_low};
   assign tx_octet       = par_data;
   assign parallel_mode  = ctrl.parallel_mode_select;                // [R23]
   assign send_request   = send_req_any;

endmodule
`default_nettype wire

// [logic/mpsf_sync.sv]
// Two-flop synchroniser for a vector of pin inputs.
// Assumes levels; multi-bit values stay stable under the host strobe.
`timescale 1ns/1ps
`default_nettype none
module mpsf_sync #(
   parameter int W = 15
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);

   logic [W-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1   <= '1;
         sync_out <= '1;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule
`default_nettype wire

// [sim/modem_pump_status_flags_tb_top.sv]
// Self-checking bench of the status flag bank driven by a host model.
// Assumes all design and sim files are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "mpsf_consts.svh"
bind mpsf_status mpsf_status_assertions u_chk (.core_clk(core_clk),
   .reset_n(reset_n), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
   .host_wr_n(host_wr_n), .host_addr(host_addr),
   .host_data_in(host_data_in), .host_data_oe(host_data_oe),
   .host_irq_pin(host_irq_pin), .line_signal_out_n(line_signal_out_n),
   .pump_ev(pump_ev), .tx_octet(tx_octet), .ram_request(ram_request));
module modem_pump_status_flags_tb_top;
   import mpsf_pkg::*;
   // Bit positions of pulse events in ev
   localparam int P_DMR = 23, P_V29 = 22, P_RTR = 18, P_TXS = 17;
   localparam int P_RAM = 14, P_RXV = 13, P_TXT = 4, P_STB = 3;
   logic          core_clk, reset_n, cs_n, rd_n, wr_n, irq, line_n, par_mode;
   logic [2:0]    addr;
   logic [7:0]    din, dout, tx_oct, q;
   mpsf_pump_ev_t ev;
   int            n_errors = 0, comparisons = 0, cycles = 0;
   mpsf_status dut (.core_clk(core_clk), .reset_n(reset_n),
      .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .host_addr(addr), .host_data_in(din), .host_data_out(dout),
      .host_data_oe(), .host_irq_pin(irq), .rts_pin_n(1'b1),
      .line_signal_out_n(line_n), .pump_ev(ev), .ram_read_data(16'h1234),
      .ram_request(), .ram_write(), .ram_address(), .ram_write_data(),
      .tx_octet(tx_oct), .parallel_mode(par_mode), .send_request());
   mpsf_host_model u_host (.core_clk(core_clk), .host_data_out(dout),
      .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n),
      .host_addr(addr), .host_data_in(din));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Whole run needs about 410 clocks; a hang ends at 5000
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // One-clock event, then one clock for the flag to land
   task automatic pulse(input int b);
      ev[b] = 1'b1;
      step(1);
      ev[b] = 1'b0;
      step(1);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_host.access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [2:0] a);
      u_host.access(1'b0, a, 8'h00, q);
   endtask
   // Whole byte compared, so the reserved bit is checked every time
   task automatic st(input logic [7:0] exp);
      rd(`MPSF_REG_STATUS);
      chk(q, exp);
   endtask
   task automatic t_reset();
      st(8'h01);
      step(50);
      st(8'h40);
      rd(`MPSF_REG_PAR_DATA);
      st(8'h00);
      ev.hdlc_bits = 3'b101;
      rd(`MPSF_REG_HDLC);
      chk(q, 8'h05);
      $display("reset test done");
   endtask
   task automatic t_carrier();
      pulse(P_DMR);
      chk1(line_n, 1'b0);
      st(8'h02);
      ev.no_remote_signal = 1'b1;
      step(2);
      chk1(line_n, 1'b1);
      ev.no_remote_signal = 1'b0;
      pulse(P_V29);
      st(8'h02);
      ev.retrain_active = 1'b1;
      st(8'h00);
      ev.retrain_active = 1'b0;
      pulse(P_DMR);
      pulse(P_STB);
      st(8'h00);
      pulse(P_RTR);
      st(8'h00);
      ev.v22bis_2400_mode = 1'b1;
      pulse(P_RTR);
      st(8'h04);
      ev.v22bis_2400_mode = 1'b0;
      $display("carrier test done");
   endtask
   task automatic t_busy();
      pulse(P_TXS);
      st(8'h00);
      wr(`MPSF_REG_RAM_CTRL, 8'h08);
      pulse(P_TXS);
      st(8'h10);
      wr(`MPSF_REG_RAM_CTRL, 8'h00);
      st(8'h10);
      ev.tx_buffers_empty = 1'b1;
      st(8'h00);
      ev.tx_buffers_empty = 1'b0;
      wr(`MPSF_REG_RAM_CTRL, 8'h08);
      pulse(P_TXS);
      pulse(P_STB);
      st(8'h00);
      wr(`MPSF_REG_RAM_CTRL, 8'h00);
      ev.tx_buffers_empty = 1'b1;
      ev.dialing_active = 1'b1;
      st(8'h10);
      ev.dialing_active = 1'b0;
      st(8'h00);
      $display("busy test done");
   endtask
   task automatic t_par();
      wr(`MPSF_REG_RAM_CTRL, 8'hd0);
      chk1(par_mode, 1'b1);
      chk1(irq, 1'b0);
      ev.rx_octet = 8'ha5;
      pulse(P_RXV);
      chk1(irq, 1'b1);
      st(8'h40);
      rd(`MPSF_REG_PAR_DATA);
      chk(q, 8'ha5);
      st(8'h00);
      pulse(P_TXT);
      st(8'h80);
      wr(`MPSF_REG_PAR_DATA, 8'h3c);
      chk(tx_oct, 8'h3c);
      chk1(irq, 1'b0);
      wr(`MPSF_REG_STATUS, 8'hff);
      wr(`MPSF_REG_RAM_CTRL, 8'h22);
      pulse(P_RAM);
      chk1(irq, 1'b1);
      st(8'h20);
      wr(`MPSF_REG_RAM_CTRL, 8'h00);
      chk1(par_mode, 1'b0);
      $display("parallel test done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      ev      = '0;
      step(10);
      reset_n = 1'b1;
      t_reset();
      t_carrier();
      t_busy();
      t_par();
      report_and_stop();
   end
endmodule
`default_nettype wire

// [sim/mpsf_host_model.sv]
// Host processor model on the parallel register port.
// Assumes its task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module mpsf_host_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] host_data_out,
   output var  logic       host_cs_n,
   output var  logic       host_rd_n,
   output var  logic       host_wr_n,
   output var  logic [2:0] host_addr,
   output var  logic [7:0] host_data_in
);
   // Bus idle from time zero
   initial begin
      host_cs_n    = 1'b1;
      host_rd_n    = 1'b1;
      host_wr_n    = 1'b1;
      host_addr    = 3'h0;
      host_data_in = 8'h00;
   end
   // Strobes 5 clocks low and 5 high, over the 3 that sync needs
   // Never touches HDLC framing, so the busy flag stays meaningful
   task automatic access(input logic wr, input logic [2:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      host_cs_n    = 1'b0;
      host_addr    = a;
      host_data_in = wr ? d : ~host_data_in;
      host_wr_n    = ~wr;
      host_rd_n    = wr;
      repeat (5) @(posedge core_clk);
      q = host_data_out;
      #1;
      host_cs_n    = 1'b1;
      host_wr_n    = 1'b1;
      host_rd_n    = 1'b1;
      host_data_in = ~host_data_in; // Released bus never keeps old data
      repeat (5) @(posedge core_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// [sim/mpsf_status_assertions.sv]
// Checker of the status flag bank, watching top-level ports only.
// Assumes a bind to mpsf_status.
`timescale 1ns/1ps
`default_nettype none
`include "mpsf_consts.svh"
module mpsf_status_assertions
   import mpsf_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          reset_n,
   input wire logic          host_cs_n,
   input wire logic          host_rd_n,
   input wire logic          host_wr_n,
   input wire logic [2:0]    host_addr,
   input wire logic [7:0]    host_data_in,
   input wire logic          host_data_oe,
   input wire logic          host_irq_pin,
   input wire logic          line_signal_out_n,
   input wire mpsf_pump_ev_t pump_ev,
   input wire logic [7:0]    tx_octet,
   input wire logic          ram_request
);
   localparam int SEQ = `MPSF_RESET_SEQ_CYC;
   logic [7:0] seq_cnt;
   logic [7:0] wr_byte;
   logic       run;
   logic       lost;
   // Counts out the reset sequence
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         seq_cnt <= 8'h00;
      else if (seq_cnt != SEQ[7:0])
         seq_cnt <= seq_cnt + 8'h01;
   end
   // Last byte seen under a write strobe
   always_ff @(posedge core_clk) begin
      if (!host_wr_n)
         wr_byte <= host_data_in;
   end
   // Carrier clear conditions, which beat set events
   assign run  = (seq_cnt == SEQ[7:0]);
   assign lost = pump_ev.retrain_active | pump_ev.no_remote_signal |
                 pump_ev.standby_write;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence rd_start;
      $fell(host_rd_n) && !host_cs_n;
   endsequence
   sequence wr3_end;
      $rose(host_wr_n) && $past(!host_cs_n) && run &&
      host_addr == `MPSF_REG_PAR_DATA;
   endsequence
   sequence carrier_up;
      run && !lost && (pump_ev.data_mode_ready || pump_ev.v29_rx_ready);
   endsequence
   rd_oe_a: assert property (rd_start |-> ##[2:4] host_data_oe)
      else $error("read data late");
   rd_drop_a: assert property ($rose(host_rd_n) |-> ##[2:4] !host_data_oe)
      else $error("read drive held");
   wr_data_a: assert property (wr3_end |-> ##[1:4] tx_octet == wr_byte)
      else $error("data byte lost");
   car_set_a: assert property (carrier_up |=>
      !line_signal_out_n)
      else $error("carrier not set");
   car_lost_a: assert property (lost |=> line_signal_out_n)
      else $error("carrier not cleared");
   car_hold_a: assert property (!line_signal_out_n && !lost |=>
      !line_signal_out_n)
      else $error("carrier dropped");
   line_src_a: assert property ($fell(line_signal_out_n) |->
      $past(pump_ev.data_mode_ready || pump_ev.v29_rx_ready))
      else $error("carrier rose alone");
   seq_quiet_a: assert property (!run |-> line_signal_out_n &&
      !host_irq_pin && !ram_request)
      else $error("active in reset");
endmodule
`default_nettype wire
